/* inc/dsa_pkg.sv */
// Purpose: Shared constants for the dual-slope converter sequencer
// Assumes: Five-digit packed BCD count, one oscillator clock
// Notes:   Counts are packed BCD so compares read as decimal
package dsa_pkg;

  localparam int unsigned OSC_HZ      = 40_000_000;
  localparam int unsigned CNT_W       = 20;
  localparam int unsigned NUM_DIGITS  = 5;
  localparam int unsigned CODE_W      = 7;
  localparam int unsigned RESULT_W    = 17;

  // Phase boundaries as packed BCD
  localparam logic [19:0] CNT_HOLD    = 20'h20000;
  localparam logic [19:0] CNT_AZ_END  = 20'h30000;
  localparam logic [19:0] CNT_IN_LAST = 20'h39999;
  localparam logic [19:0] CNT_REF_MAX = 20'h19999;
  localparam logic [19:0] CNT_ZERO    = 20'h00000;

  // Hold mode trigger poll period, oscillator pulses
  localparam int unsigned HOLD_POLL   = 4000;
  localparam logic [11:0] HOLD_LAST   = 12'(HOLD_POLL - 1);

  // Display scan divider, oscillator pulses per digit
  localparam int unsigned SCAN_DIV    = 200;
  localparam logic [7:0]  SCAN_LAST   = 8'(SCAN_DIV - 1);
  localparam logic [2:0]  DIG_LAST    = 3'h4;

  localparam logic [6:0]  BCD_BLANK   = 7'h0f;
  localparam logic [6:0]  SEG_BLANK   = 7'h00;
  localparam logic [6:0]  SEG_MINUS   = 7'h40;

  // Gray ordered along auto-zero, input, reference
  typedef enum logic [1:0] {
    PH_AUTO_ZERO = 2'h0,
    PH_INT_IN    = 2'h1,
    PH_INT_REF   = 2'h3,
    PH_HOLD      = 2'h2
  } dsa_phase_type;

endpackage : dsa_pkg

/* hdl/dsa_sequencer.sv */
// Purpose: Control and readout for a dual-slope integrating converter
// Assumes: ref_clk is the oscillator, driven or free-running
// Notes:   Pins trigger, comp_out and seg_mode pass two flops first
`timescale 1ns/100ps

module dsa_sequencer (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire logic                         trigger,
  input  wire logic                         comp_out,
  input  wire logic                         seg_mode,
  output logic                              ctl_sel0,
  output logic                              ctl_sel1,
  output logic [dsa_pkg::CODE_W-1:0]        digit_code,
  output logic [dsa_pkg::NUM_DIGITS-1:0]    digit_en,
  output logic                              sign_out,
  output logic                              over_range,
  output logic                              result_strobe
);
  import dsa_pkg::*;

  typedef struct packed {
    logic [1:0]            trig_sync;
    logic [1:0]            comp_sync;
    logic [1:0]            mode_sync;
    logic                  half_en;
    dsa_phase_type         phase;
    logic [CNT_W-1:0]      count;
    logic [11:0]           hold_cnt;
    logic                  polarity;
    logic [RESULT_W-1:0]   result;
    logic                  res_sign;
    logic                  res_over;
    logic [7:0]            scan_cnt;
    logic [2:0]            scan_pos;
    logic                  sel0;
    logic                  sel1;
    logic [CODE_W-1:0]     code;
    logic [NUM_DIGITS-1:0] den;
    logic                  sign;
    logic                  over;
    logic                  strobe;
  } dsa_state_type;

  dsa_state_type st;
  dsa_state_type next_st;

  // Active-high segments g..a
  function automatic logic [6:0] seg_of(input logic [3:0] d);
    logic [6:0] s;
    s = SEG_BLANK;
    case (d)
      4'h0: s = 7'h3f;
      4'h1: s = 7'h06;
      4'h2: s = 7'h5b;
      4'h3: s = 7'h4f;
      4'h4: s = 7'h66;
      4'h5: s = 7'h6d;
      4'h6: s = 7'h7d;
      4'h7: s = 7'h07;
      4'h8: s = 7'h7f;
      4'h9: s = 7'h6f;
      default: s = SEG_BLANK;
    endcase
    return s;
  endfunction : seg_of

  logic                  trig_s;
  logic                  comp_s;
  logic                  mode_s;
  logic [3:0]            cur_digit;
  logic                  cur_blank;
  logic                  crossed;
  wire  [CNT_W-1:0]      count_inc;
  wire  [NUM_DIGITS:0]   inc_carry;
  wire  [3:0]            shown [NUM_DIGITS];
  wire  [NUM_DIGITS-1:0] blank_of;
  wire  [NUM_DIGITS-1:0] strobe_of;

  assign trig_s = st.trig_sync[1];
  assign comp_s = st.comp_sync[1];
  assign mode_s = st.mode_sync[1];
  // Integrator back at zero once comparator leaves the sampled polarity
  assign crossed = (comp_s != st.polarity);

  // Packed BCD increment, one carry stage per decade
  assign inc_carry[0] = 1'b1;

  for (genvar g = 0; g < NUM_DIGITS; g++) begin : gen_decade
    logic [3:0] dec;
    logic [3:0] dec_next;
    logic       at_nine;

    assign dec     = st.count[g*4 +: 4];
    assign at_nine = (dec == 4'h9);

    always_comb begin
      if (!inc_carry[g]) begin
        dec_next = dec;
      end else if (at_nine) begin
        dec_next = 4'h0;
      end else begin
        dec_next = dec + 4'h1;
      end
    end

    assign inc_carry[g+1]      = inc_carry[g] & at_nine;
    assign count_inc[g*4 +: 4] = dec_next;
  end : gen_decade

  // Each display position prepared once; the scan only selects
  for (genvar p = 0; p < NUM_DIGITS; p++) begin : gen_pos
    if (p == NUM_DIGITS - 1) begin : gen_half
      // Half digit stays lit so an over-range still reads
      assign shown[p]    = {3'h0, st.result[RESULT_W-1]};
      assign blank_of[p] = 1'b0;
    end else begin : gen_full
      assign shown[p]    = st.result[p*4 +: 4];
      assign blank_of[p] = st.res_over;
    end
    assign strobe_of[p] = (st.scan_pos == 3'(p));
  end : gen_pos

  always_comb begin
    next_st = st;
    cur_digit = 4'h0;
    cur_blank = 1'b0;

    next_st.trig_sync = {st.trig_sync[0], trigger};
    next_st.comp_sync = {st.comp_sync[0], comp_out};
    next_st.mode_sync = {st.mode_sync[0], seg_mode};
    next_st.strobe    = 1'b0;

    // Count enable on every second oscillator edge
    next_st.half_en = ~st.half_en;

    case (st.phase)
      PH_AUTO_ZERO: begin
        next_st.sel0 = 1'b0;
        next_st.sel1 = 1'b0;
        if (st.half_en) begin
          if (st.count == CNT_HOLD && !trig_s) begin
            next_st.phase    = PH_HOLD;
            next_st.hold_cnt = '0;
          end else if (count_inc == CNT_AZ_END) begin
            // Selects rise on the step that lands on the end count
            next_st.phase = PH_INT_IN;
            next_st.sel0  = 1'b1;
            next_st.sel1  = 1'b1;
            next_st.count = count_inc;
          end else begin
            next_st.count = count_inc;
          end
        end
      end
      PH_HOLD: begin
        // Counter frozen at the hold count while polling
        next_st.sel0 = 1'b0;
        next_st.sel1 = 1'b0;
        if (st.hold_cnt == HOLD_LAST) begin
          next_st.hold_cnt = '0;
          if (trig_s) begin
            next_st.phase = PH_AUTO_ZERO;
            next_st.count = count_inc;
          end
        end else begin
          next_st.hold_cnt = st.hold_cnt + 12'h001;
        end
      end
      PH_INT_IN: begin
        // Runs 30000..39999 then wraps, a fixed 10000 steps
        if (st.half_en) begin
          if (st.count == CNT_IN_LAST) begin
            next_st.count    = CNT_ZERO;
            next_st.phase    = PH_INT_REF;
            next_st.polarity = comp_s;
            next_st.sel0     = comp_s;
            next_st.sel1     = ~comp_s;
          end else begin
            next_st.count = count_inc;
          end
        end
      end

      PH_INT_REF: begin
        if (st.half_en) begin
          if (crossed) begin
            // Count taken on the step edge that sees the crossing
            next_st.result   = st.count[RESULT_W-1:0];
            next_st.res_sign = st.polarity;
            next_st.res_over = 1'b0;
            next_st.strobe   = 1'b1;
            next_st.phase    = PH_AUTO_ZERO;
            next_st.sel0     = 1'b0;
            next_st.sel1     = 1'b0;
            next_st.count    = count_inc;
          end else if (st.count == CNT_REF_MAX) begin
            // No crossing in a full span; restart at hold count
            next_st.result   = st.count[RESULT_W-1:0];
            next_st.res_sign = st.polarity;
            next_st.res_over = 1'b1;
            next_st.strobe   = 1'b1;
            next_st.phase    = PH_AUTO_ZERO;
            next_st.sel0     = 1'b0;
            next_st.sel1     = 1'b0;
            next_st.count    = count_inc;
          end else begin
            next_st.count = count_inc;
          end
        end
      end
      default: begin
        next_st.phase = PH_AUTO_ZERO;
        next_st.count = CNT_ZERO;
      end
    endcase

    // Display scan, one digit per 200 oscillator pulses
    if (st.scan_cnt == SCAN_LAST) begin
      next_st.scan_cnt = '0;
      if (st.scan_pos == DIG_LAST) begin
        next_st.scan_pos = '0;
      end else begin
        next_st.scan_pos = st.scan_pos + 3'h1;
      end
    end else begin
      next_st.scan_cnt = st.scan_cnt + 8'h01;
    end

    cur_digit = shown[st.scan_pos];
    cur_blank = blank_of[st.scan_pos];

    if (mode_s) begin
      next_st.code = cur_blank ? SEG_BLANK : seg_of(cur_digit);
    end else begin
      next_st.code = cur_blank ? BCD_BLANK : {3'h0, cur_digit};
    end
    next_st.den  = strobe_of;
    // Sign and flag move with the strobe, not a cycle later
    next_st.sign = next_st.res_sign;
    next_st.over = next_st.res_over;
  end

  // One oscillator domain for all sequencing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{
        trig_sync: 2'h0,
        comp_sync: 2'h0,
        mode_sync: 2'h0,
        half_en:   1'b0,
        phase:     PH_AUTO_ZERO,
        count:     CNT_ZERO,
        hold_cnt:  12'h000,
        polarity:  1'b0,
        result:    '0,
        res_sign:  1'b0,
        res_over:  1'b0,
        scan_cnt:  8'h00,
        scan_pos:  3'h0,
        sel0:      1'b0,
        sel1:      1'b0,
        code:      7'h00,
        den:       5'h00,
        sign:      1'b0,
        over:      1'b0,
        strobe:    1'b0
      };
    end else begin
      st <= next_st;
    end
  end

  assign ctl_sel0      = st.sel0;
  assign ctl_sel1      = st.sel1;
  assign digit_code    = st.code;
  assign digit_en      = st.den;
  assign sign_out      = st.sign;
  assign over_range    = st.over;
  assign result_strobe = st.strobe;

endmodule : dsa_sequencer

/* verification/dsa_analog_model.sv */
// Purpose: Behavioural analog processor facing the sequencer
// Assumes: vin in counts; a positive vin reads comparator high
// Notes:   Comparator wobbles in auto-zero, like the limit cycle
`timescale 1ns/100ps
module dsa_analog_model (
  input  wire logic        ref_clk,
  input  wire logic        ctl_sel0,
  input  wire logic        ctl_sel1,
  input  wire logic [31:0] vin,
  output logic             comp_out
);
  longint acc = 0;
  logic   wob = 1'b0;
  always @(posedge ref_clk) begin
    wob <= ~wob;
    case ({ctl_sel0, ctl_sel1})
      2'b11:   acc <= acc + longint'($signed(vin));
      2'b10:   acc <= acc - 64'sh2710;
      2'b01:   acc <= acc + 64'sh2710;
      default: acc <= 0;
    endcase
  end
  // Unknown level in auto-zero, never a held value
  assign comp_out = (ctl_sel0 | ctl_sel1) ? (acc > 0) : wob;
endmodule : dsa_analog_model

/* verification/dsa_sequencer_chk.sv */
// Purpose: Port checks for the converter sequencer
// Assumes: Selects 00 auto-zero, 11 input, 01 or 10 reference
// Notes:   Long spans are counted in helper logic
`timescale 1ns/100ps
module dsa_sequencer_chk
  import dsa_pkg::*;
(
  input wire logic                           ref_clk,
  input wire logic                           rst_n,
  input wire logic                           trigger,
  input wire logic                           comp_out,
  input wire logic                           seg_mode,
  input wire logic                           ctl_sel0,
  input wire logic                           ctl_sel1,
  input wire logic [dsa_pkg::CODE_W-1:0]     digit_code,
  input wire logic [dsa_pkg::NUM_DIGITS-1:0] digit_en,
  input wire logic                           sign_out,
  input wire logic                           over_range,
  input wire logic                           result_strobe
);
  localparam int IN_CLKS = 20000;
  logic [14:0] in_cnt;
  logic [7:0]  scan_cnt;
  logic [4:0]  en_q;
  logic [1:0]  arm;
  logic        ref_pol;
  logic        en_chg;
  assign en_chg = (digit_en != en_q);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_cnt   <= '0;
      scan_cnt <= '0;
      en_q     <= '0;
      arm      <= '0;
      ref_pol  <= 1'b0;
    end else begin
      in_cnt   <= (ctl_sel0 && ctl_sel1) ? in_cnt + 15'h1 : '0;
      scan_cnt <= en_chg ? 8'h00 : scan_cnt + 8'h01;
      en_q     <= digit_en;
      // First scan slot may be short after reset, so arm late
      if (en_chg && arm != 2'h2) arm <= arm + 2'h1;
      if (ctl_sel0 ^ ctl_sel1) ref_pol <= ctl_sel0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence in_exit;
    (ctl_sel0 && ctl_sel1) ##1 !(ctl_sel0 && ctl_sel1);
  endsequence
  sequence az_now;
    !ctl_sel0 && !ctl_sel1;
  endsequence
  in_to_ref_a: assert property (in_exit |-> ctl_sel0 != ctl_sel1)
    else $error("input phase not followed by reference");
  az_exit_a: assert property (az_now |=> !(ctl_sel0 ^ ctl_sel1))
    else $error("auto-zero left straight to reference");
  ref_exit_a: assert property ((ctl_sel0 ^ ctl_sel1) |=>
    $stable({ctl_sel0, ctl_sel1}) || (!ctl_sel0 && !ctl_sel1))
    else $error("reference not followed by auto-zero");
  in_span_a: assert property (!(ctl_sel0 && ctl_sel1) &&
    in_cnt != 15'h0 |-> in_cnt == IN_CLKS)
    else $error("input phase length wrong");
  sign_kept_a: assert property (result_strobe |-> sign_out == ref_pol)
    else $error("sign differs from reference polarity");
  strobe_one_a: assert property (result_strobe |=> !result_strobe)
    else $error("result strobe longer than one cycle");
  xfer_end_a: assert property (result_strobe |-> az_now ##0
    ($past(ctl_sel0 ^ ctl_sel1) || $past(ctl_sel0 ^ ctl_sel1, 2)))
    else $error("result not at end of reference");
  scan_rate_a: assert property (arm == 2'h2 && en_chg |->
    scan_cnt == SCAN_LAST)
    else $error("digit scan period wrong");
  scan_hot_a: assert property (arm != 2'h0 |-> $onehot(digit_en))
    else $error("digit strobe not one-hot");
  blank_a: assert property (over_range && $past(over_range) &&
    digit_en[3:0] != 4'h0 |-> digit_code == (seg_mode ? SEG_BLANK : BCD_BLANK))
    else $error("over-range digit not blank");
endmodule : dsa_sequencer_chk

/* verification/tb.sv */
// Purpose: Self-checking bench for the converter sequencer
// Assumes: One conversion entered through hold, then a readout
// Notes:   A full cycle is 80k clocks, so only one conversion
`timescale 1ns/100ps
module tb;
  import dsa_pkg::*;
  typedef struct packed {
    logic        sign;
    logic [16:0] mag;
  } dsa_note_type;
  logic                  ref_clk = 1'b0;
  logic                  rst_n, trigger, seg_mode, comp_out;
  logic                  ctl_sel0, ctl_sel1, sign_out, over_range;
  logic                  result_strobe;
  logic [CODE_W-1:0]     digit_code;
  logic [NUM_DIGITS-1:0] digit_en;
  logic [31:0]           vin;
  dsa_note_type          notes[$];
  int                    fail_count = 0;
  int                    num_checks = 0;
  logic                  got_result = 1'b0;
  logic [3:0]            dig[5];
  localparam logic [6:0] SEG_REF [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f,
    7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
  always #12.5 ref_clk = ~ref_clk;
  dsa_sequencer uut (.ref_clk(ref_clk), .rst_n(rst_n), .trigger(trigger),
    .comp_out(comp_out), .seg_mode(seg_mode), .ctl_sel0(ctl_sel0),
    .ctl_sel1(ctl_sel1), .digit_code(digit_code), .digit_en(digit_en),
    .sign_out(sign_out), .over_range(over_range),
    .result_strobe(result_strobe));
  dsa_analog_model far (.ref_clk(ref_clk), .ctl_sel0(ctl_sel0),
    .ctl_sel1(ctl_sel1), .vin(vin), .comp_out(comp_out));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic print_verdict();
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : check
  task automatic wait_sel(input logic [1:0] s, input int lim, output int n);
    n = 0;
    while ({ctl_sel0, ctl_sel1} !== s && n <= lim) begin
      @(negedge ref_clk);
      n++;
    end
    if (n > lim) begin
      check(1'b0, "select wait ran out");
      print_verdict();
    end
  endtask : wait_sel
  initial begin : drive
    int          n;
    logic [31:0] rnd;
    logic [16:0] mag;
    rst_n = 1'b0;
    trigger = 1'b0;
    seg_mode = 1'b0;
    rnd = lfsr(32'h201e4c29);
    mag = 17'(rnd[9:0]) + 17'h64;
    vin = rnd[0] ? 32'(mag) : -32'(mag);
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    // Hold is entered near 40000 clocks; raise trigger inside it
    repeat (41000) @(negedge ref_clk);
    trigger = 1'b1;
    wait_sel(2'b11, 24100, n);
    check(n >= 19500, "hold not kept");
    notes.push_back({rnd[0], mag});
    wait_sel({rnd[0], ~rnd[0]}, 20010, n);
    check(n >= 19990, "input span short");
    for (n = 0; n < 9000 && !got_result; n++) @(negedge ref_clk);
    check(got_result, "no result");
    // Same latched digits again, now as segment patterns
    seg_mode = 1'b1;
    repeat (4) @(negedge ref_clk);
    for (int i = 0; i < 5; i++) begin
      n = 0;
      while (digit_en !== (5'h01 << i) && n < 1100) begin
        @(negedge ref_clk);
        n++;
      end
      check(n < 1100 && digit_code === SEG_REF[dig[i]], "seg");
    end
    print_verdict();
  end
  initial begin : watch
    dsa_note_type e;
    int unsigned  v;
    int unsigned  w;
    int           k;
    forever begin
      @(negedge ref_clk);
      if (result_strobe === 1'b1 && notes.size() > 0) begin
        e = notes.pop_front();
        check(sign_out === e.sign, "sign");
        check(over_range === 1'b0, "false over-range");
        // Codes follow the latch by one clock
        @(negedge ref_clk);
        v = 0;
        w = 1;
        for (int i = 0; i < 5; i++) begin
          k = 0;
          while (digit_en !== (5'h01 << i) && k < 1100) begin
            @(negedge ref_clk);
            k++;
          end
          check(k < 1100 && digit_code[6:4] === 3'h0, "digit");
          dig[i] = digit_code[3:0];
          v = v + w * digit_code[3:0];
          w = w * 10;
        end
        // Comparator sync and step grain blur the last count or two
        check(v + 3 >= e.mag && v <= e.mag + 3, "count");
        got_result = 1'b1;
      end
    end
  end
endmodule : tb
bind dsa_sequencer dsa_sequencer_chk chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .trigger(trigger), .comp_out(comp_out), .seg_mode(seg_mode),
  .ctl_sel0(ctl_sel0), .ctl_sel1(ctl_sel1), .digit_code(digit_code),
  .digit_en(digit_en), .sign_out(sign_out), .over_range(over_range),
  .result_strobe(result_strobe));
